// [pkg/owd_regs.vh]
`ifndef OWD_REGS_VH
`define OWD_REGS_VH

// ------------------------------------------------------------------
// Register byte offsets on the programming port
// ------------------------------------------------------------------
`define OWD_OFS_OPTION 4'h0
`define OWD_OFS_USERID 4'h4
`define OWD_OFS_STATUS 4'h8
`define OWD_OFS_DECODE 4'hC

// ------------------------------------------------------------------
// Storage word indices and widths
// ------------------------------------------------------------------
`define OWD_IDX_OPTION 1'b0
`define OWD_IDX_USERID 1'b1
`define OWD_WORD_W 13
`define OWD_ERASED 13'h1FFF

// ------------------------------------------------------------------
// Option word field positions
// ------------------------------------------------------------------
`define OWD_BIT_OSC_TYPE 12
`define OWD_BIT_WDT_DIS_N 11
`define OWD_BIT_CYC_LEN 10
`define OWD_BIT_PROT_N 9
`define OWD_BIT_XTAL_RANGE 8
`define OWD_BIT_RC_SRC 7
`define OWD_BIT_OSC_PWR 6
`define OWD_UNUSED_MASK 13'h003F

// ------------------------------------------------------------------
// Status and decode readback field positions
// ------------------------------------------------------------------
`define OWD_ST_LOADED 0
`define OWD_ST_RANGE_WARN 1
`define OWD_ST_PWR_WARN 2
`define OWD_DEC_EXT_RC 0
`define OWD_DEC_INT_RC 1
`define OWD_DEC_HXT 2
`define OWD_DEC_LXT 3
`define OWD_DEC_WDT_EN 4
`define OWD_DEC_PROT_EN 5
`define OWD_DEC_DIV4 6
`define OWD_DEC_HIPWR 7

// ------------------------------------------------------------------
// Timing and frequency constants
// ------------------------------------------------------------------
`define OWD_CYC_PERIODS_SHORT 3'h2
`define OWD_CYC_PERIODS_LONG 3'h4
`define OWD_TMR_DIV_SHORT 3'h2
`define OWD_TMR_DIV_LONG 3'h4
`define OWD_IRC_NOM_KHZ 13'h0FA0
`define OWD_RST_DECODE 13'h0000

`endif

// [src/owd_otp_mem.v]
`include "owd_regs.vh"

module owd_otp_mem (
  // Clock
  input wire mclk,
  input wire ce,
  // Access port
  input wire wr_en,
  input wire rd_en,
  input wire addr,
  input wire [12:0] wr_data,
  output reg [12:0] rd_data_ff
);

  reg [12:0] word_ff [0:1];

  // ------------------------------------------------------------------
  // Non-volatile contents: srst must not wipe them, so erased at power-up
  // ------------------------------------------------------------------
  integer i;
  initial begin
    for (i = 0; i < 2; i = i + 1) begin
      word_ff[i] = `OWD_ERASED;
    end
  end

  // Programming only clears bits, like a real fuse array
  always @(posedge mclk) begin
    if (ce) begin
      if (wr_en) begin
        word_ff[addr] <= word_ff[addr] & wr_data;
      end
      if (rd_en) begin
        rd_data_ff <= word_ff[addr];
      end
    end
  end

endmodule // owd_otp_mem

// [src/owd_option_decoder.v]
// Operation
// [RULE_01] Option bit 12 zero selects RC oscillator, one selects crystal.
// [RULE_02] Option bit 11 zero enables watchdog, one disables it.
// [RULE_03] Option bit 10 picks two or four oscillator periods per cycle.
// [RULE_04] Option bit 9 zero enables code protection, one disables it.
// [RULE_05] Option bit 8 zero picks low crystal range, one high range.
// [RULE_06] Range bit matters only in crystal type; programmer writes it zero otherwise.
// [RULE_07] Option bit 7 zero uses internal capacitor, one external RC.
// [RULE_08] Option bit 6 selects oscillator power; bits 5 to 0 unused.
// [RULE_09] Option word lives outside program memory, no program access.
// [RULE_10] Thirteen-bit user ID held outside program memory, no program access.
// [RULE_11] Internal capacitor RC mode runs nominally at 4 MHz.
// [RULE_12] Oscillator mode derived from type, range, power and RC-select bits; the mode outputs here ignore the power bit.
// [RULE_13] Four-period cycles clock timer source at oscillator divided by four.
// [RULE_14] Decoded settings are latched after reset and held constant.
`include "owd_regs.vh"

module owd_option_decoder (
  // Clock and reset
  input wire mclk,
  input wire srst,
  input wire ce,
  // Programmer port, Avalon-MM slave
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // Decoded static configuration
  output reg osc_type_xtal,
  output reg watchdog_en,
  output reg code_protect_en,
  output reg crystal_range_high,
  output reg rc_external,
  output reg osc_high_power,
  output reg external_rc_mode,
  output reg internal_cap_rc_mode,
  output reg high_crystal_mode,
  output reg low_crystal_mode,
  output reg [2:0] cycle_osc_periods,
  output reg [2:0] timer_src_div,
  output reg [12:0] nominal_freq_khz,
  output reg config_valid
);

  // ------------------------------------------------------------------
  // State encodings
  // ------------------------------------------------------------------
  localparam L_FETCH = 2'b00;
  localparam L_WAIT = 2'b01;
  localparam L_RUN = 2'b10;

  localparam B_IDLE = 2'b00;
  localparam B_RDMEM = 2'b01;
  localparam B_ACK = 2'b10;

  reg [1:0] load_st_ff;
  reg [1:0] nxt_load_st;
  reg [1:0] bus_st_ff;
  reg [1:0] nxt_bus_st;
  reg range_warn_ff;
  reg pwr_warn_ff;

  // ------------------------------------------------------------------
  // Decode helpers
  // ------------------------------------------------------------------
  wire [12:0] mem_q;
  wire [12:0] opt = mem_q;
  wire o_type = opt[`OWD_BIT_OSC_TYPE];
  wire o_wdt_n = opt[`OWD_BIT_WDT_DIS_N];
  wire o_cyc = opt[`OWD_BIT_CYC_LEN];
  wire o_prot_n = opt[`OWD_BIT_PROT_N];
  wire o_range = opt[`OWD_BIT_XTAL_RANGE];
  wire o_rcsrc = opt[`OWD_BIT_RC_SRC];
  wire o_pwr = opt[`OWD_BIT_OSC_PWR];

  wire bus_req = avs_read | avs_write;
  wire is_opt = (avs_address == `OWD_OFS_OPTION);
  wire is_id = (avs_address == `OWD_OFS_USERID);
  wire is_mem = is_opt | is_id;
  wire be_ok = (avs_byteenable[1:0] == 2'b11);
  wire loading = (load_st_ff != L_RUN);

  // ------------------------------------------------------------------
  // Shared storage port: loader owns it until the settings are latched
  // ------------------------------------------------------------------
  // Only the programmer port and the loader reach the storage [RULE_09] [RULE_10]
  wire mem_wr = ~loading & (bus_st_ff == B_IDLE) & avs_write & is_mem & be_ok;
  wire mem_rd = loading | ((bus_st_ff == B_IDLE) & avs_read & is_mem);
  wire mem_addr = loading ? `OWD_IDX_OPTION : is_id;

  owd_otp_mem u_mem (
    .mclk(mclk),
    .ce(ce),
    .wr_en(mem_wr),
    .rd_en(mem_rd),
    .addr(mem_addr),
    .wr_data(avs_writedata[12:0]),
    .rd_data_ff(mem_q)
  );

  // ------------------------------------------------------------------
  // Loader: one fetch after reset, then the settings stay frozen
  // ------------------------------------------------------------------
  always @* begin
    nxt_load_st = load_st_ff;
    case (load_st_ff)
      L_FETCH: nxt_load_st = L_WAIT;
      L_WAIT: nxt_load_st = L_RUN;
      L_RUN: nxt_load_st = L_RUN;
      default: nxt_load_st = L_FETCH;
    endcase
  end

  always @(posedge mclk) begin
    if (srst) begin
      load_st_ff <= L_FETCH;
      osc_type_xtal <= 1'b0;
      watchdog_en <= 1'b0;
      code_protect_en <= 1'b0;
      crystal_range_high <= 1'b0;
      rc_external <= 1'b0;
      osc_high_power <= 1'b0;
      external_rc_mode <= 1'b0;
      internal_cap_rc_mode <= 1'b0;
      high_crystal_mode <= 1'b0;
      low_crystal_mode <= 1'b0;
      cycle_osc_periods <= `OWD_CYC_PERIODS_SHORT;
      timer_src_div <= `OWD_TMR_DIV_SHORT;
      nominal_freq_khz <= `OWD_RST_DECODE;
      config_valid <= 1'b0;
      range_warn_ff <= 1'b0;
      pwr_warn_ff <= 1'b0;
    end else if (ce) begin
      load_st_ff <= nxt_load_st;
      // Captured once; later programming shows only after the next reset [RULE_14]
      if (load_st_ff == L_WAIT) begin
        osc_type_xtal <= o_type; // [RULE_01]
        watchdog_en <= ~o_wdt_n; // [RULE_02]
        code_protect_en <= ~o_prot_n; // [RULE_04]
        // Range bit is ignored in RC type [RULE_05] [RULE_06]
        crystal_range_high <= o_type & o_range;
        rc_external <= ~o_type & o_rcsrc; // [RULE_07]
        osc_high_power <= o_pwr; // [RULE_08]
        external_rc_mode <= ~o_type & o_rcsrc; // [RULE_12]
        internal_cap_rc_mode <= ~o_type & ~o_rcsrc; // [RULE_12]
        high_crystal_mode <= o_type & o_range; // [RULE_12]
        // Low crystal with high power is not a listed mode; it still runs low crystal
        low_crystal_mode <= o_type & ~o_range; // [RULE_12]
        cycle_osc_periods <= o_cyc ? `OWD_CYC_PERIODS_LONG : `OWD_CYC_PERIODS_SHORT; // [RULE_03]
        timer_src_div <= o_cyc ? `OWD_TMR_DIV_LONG : `OWD_TMR_DIV_SHORT; // [RULE_13]
        nominal_freq_khz <= (~o_type & ~o_rcsrc) ? `OWD_IRC_NOM_KHZ : `OWD_RST_DECODE; // [RULE_11]
        config_valid <= 1'b1;
        // Programmer broke the range-bit convention in RC type [RULE_06]
        range_warn_ff <= ~o_type & o_range;
        pwr_warn_ff <= o_type & ~o_range & o_pwr;
      end
    end
  end

  // ------------------------------------------------------------------
  // Programmer port
  // ------------------------------------------------------------------
  always @* begin
    nxt_bus_st = bus_st_ff;
    case (bus_st_ff)
      B_IDLE: begin
        if (bus_req & ~loading) begin
          nxt_bus_st = (avs_read & is_mem) ? B_RDMEM : B_ACK;
        end
      end
      B_RDMEM: nxt_bus_st = B_ACK;
      B_ACK: nxt_bus_st = B_IDLE;
      default: nxt_bus_st = B_IDLE;
    endcase
  end

  always @(posedge mclk) begin
    if (srst) begin
      bus_st_ff <= B_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else if (ce) begin
      bus_st_ff <= nxt_bus_st;
      avs_waitrequest <= ~((nxt_bus_st == B_ACK) & (bus_st_ff != B_ACK));
      if (bus_st_ff == B_RDMEM) begin
        // Protected parts hide both words from readback
        avs_readdata <= code_protect_en ? 32'h0000_0000 : {19'h0_0000, mem_q};
      end else if ((bus_st_ff == B_IDLE) & avs_read & ~loading) begin
        if (avs_address == `OWD_OFS_STATUS) begin
          avs_readdata <= {29'h0000_0000, pwr_warn_ff, range_warn_ff, config_valid};
        end else if (avs_address == `OWD_OFS_DECODE) begin
          avs_readdata <= {24'h00_0000, osc_high_power, (timer_src_div == `OWD_TMR_DIV_LONG),
                           code_protect_en, watchdog_en, low_crystal_mode, high_crystal_mode,
                           internal_cap_rc_mode, external_rc_mode};
        end else begin
          avs_readdata <= 32'h0000_0000;
        end
      end
    end
  end

endmodule // owd_option_decoder

// [tb/owd_option_decoder_monitor.sv]
module owd_option_decoder_monitor (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Bus answer
  input wire logic avs_waitrequest,
  // Decoded configuration
  input wire logic osc_type_xtal,
  input wire logic watchdog_en,
  input wire logic code_protect_en,
  input wire logic crystal_range_high,
  input wire logic rc_external,
  input wire logic osc_high_power,
  input wire logic external_rc_mode,
  input wire logic internal_cap_rc_mode,
  input wire logic high_crystal_mode,
  input wire logic low_crystal_mode,
  input wire logic [2:0] cycle_osc_periods,
  input wire logic [2:0] timer_src_div,
  input wire logic [12:0] nominal_freq_khz,
  input wire logic config_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_ack_pulse;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");

  property p_load;
    $fell(srst) |-> ##[1:4] config_valid;
  endproperty
  a_load: assert property (p_load) else $error("option word not latched after reset");

  property p_onehot;
    config_valid |-> $onehot({external_rc_mode, internal_cap_rc_mode, high_crystal_mode, low_crystal_mode});
  endproperty
  a_onehot: assert property (p_onehot) else $error("oscillator mode not unique");

  property p_xtal;
    config_valid |-> osc_type_xtal == (high_crystal_mode | low_crystal_mode);
  endproperty
  a_xtal: assert property (p_xtal) else $error("type and mode disagree");

  property p_range;
    config_valid |-> crystal_range_high == high_crystal_mode;
  endproperty
  a_range: assert property (p_range) else $error("range outside crystal type");

  property p_div;
    config_valid |-> timer_src_div == cycle_osc_periods && cycle_osc_periods inside {3'h2, 3'h4};
  endproperty
  a_div: assert property (p_div) else $error("timer divider mismatch");

  property p_freq;
    config_valid |-> nominal_freq_khz == (internal_cap_rc_mode ? 13'h0FA0 : 13'h0000);
  endproperty
  a_freq: assert property (p_freq) else $error("nominal frequency wrong");

  property p_rcsel;
    config_valid |-> rc_external == external_rc_mode;
  endproperty
  a_rcsel: assert property (p_rcsel) else $error("rc source mismatch");

  property p_hold;
    config_valid |=> $stable({osc_type_xtal, watchdog_en, code_protect_en, osc_high_power,
      external_rc_mode, internal_cap_rc_mode, high_crystal_mode, low_crystal_mode, config_valid});
  endproperty
  a_hold: assert property (p_hold) else $error("configuration changed in operation");
endmodule // owd_option_decoder_monitor

bind owd_option_decoder owd_option_decoder_monitor u_mon (.*);

// [tb/owd_prog_model.sv]
module owd_prog_model (
  // Clock
  input wire logic mclk,
  // Avalon-MM master side
  output logic [3:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    avs_address = 4'hF;
    avs_read = 1'h0;
    avs_write = 1'h0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hF;
  end

  // ----------------------------------------------------------------
  // One transfer, held until the slave drops waitrequest
  // ----------------------------------------------------------------
  task automatic xfer(input logic rw, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= rw;
    avs_read <= !rw;
    do @(posedge mclk); while (avs_waitrequest !== 1'h0);
    q = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    // Released lines show the inverse so a stale value cannot pass
    avs_address <= ~a;
    avs_writedata <= ~d;
  endtask
endmodule // owd_prog_model

// [tb/owd_option_decoder_tb.sv]
module owd_option_decoder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, srst, ce;
  wire [3:0] avs_address, avs_byteenable;
  wire avs_read, avs_write, avs_waitrequest;
  wire [31:0] avs_writedata, avs_readdata;
  wire osc_type_xtal, watchdog_en, code_protect_en, crystal_range_high, rc_external, osc_high_power;
  wire external_rc_mode, internal_cap_rc_mode, high_crystal_mode, low_crystal_mode, config_valid;
  wire [2:0] cycle_osc_periods, timer_src_div;
  wire [12:0] nominal_freq_khz;
  integer fails, comparisons;
  logic [31:0] q;
  logic [12:0] prev;
  // RC-type words keep the range bit clear
  // Each word only clears bits of the one before, as a fuse array allows
  logic [12:0] vs [4] = '{13'h1EBF, 13'h0ABF, 13'h0A3F, 13'h003F};

  owd_option_decoder DUT (.*);
  owd_prog_model u_prog (.*);

  initial begin
    mclk = 1'h0;
    forever #2.5 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // Checking helpers
  // ----------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task dchk(input logic [12:0] w);
    chk({osc_type_xtal, watchdog_en, code_protect_en, crystal_range_high, rc_external, osc_high_power,
      external_rc_mode, internal_cap_rc_mode, high_crystal_mode, low_crystal_mode, cycle_osc_periods,
      timer_src_div, nominal_freq_khz, config_valid},
      {w[12], ~w[11], ~w[9], w[12] & w[8], ~w[12] & w[7], w[6], ~w[12] & w[7], ~w[12] & ~w[7],
      w[12] & w[8], w[12] & ~w[8], w[10] ? 6'h24 : 6'h12, (w[12] | w[7]) ? 13'h0000 : 13'h0FA0, 1'h1});
  endtask

  task rst;
    integer n;
    // Reset acts with ce low; the loader must stay frozen until ce rises
    srst <= 1'h1;
    ce <= 1'h0;
    repeat (10) @(posedge mclk);
    srst <= 1'h0;
    repeat (2) @(posedge mclk);
    ce <= 1'h1;
    @(negedge mclk);
    chk(config_valid, 1'h0);
    for (n = 0; n < 20 && config_valid !== 1'h1; n++) @(posedge mclk);
    chk(config_valid, 1'h1);
  endtask

  task final_report;
    $display("Comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Whole run needs about a microsecond
  initial begin
    #20000;
    fails++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    final_report;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    fails = 0;
    comparisons = 0;
    prev = 13'h1FFF;
    rst();
    dchk(prev);
    u_prog.xfer(1'h0, 4'h8, 32'h0000_0000, q);
    chk(q, 32'h0000_0001);
    u_prog.xfer(1'h0, 4'hC, 32'h0000_0000, q);
    chk(q, 32'h0000_00C4);
    u_prog.xfer(1'h0, 4'h0, 32'h0000_0000, q);
    chk(q, 32'h0000_1FFF);
    u_prog.xfer(1'h0, 4'h2, 32'h0000_0000, q);
    chk(q, 32'h0000_0000);
    u_prog.xfer(1'h1, 4'h4, 32'h0000_1A5A, q);
    u_prog.xfer(1'h0, 4'h4, 32'h0000_0000, q);
    chk(q, 32'h0000_1A5A);
    foreach (vs[i]) begin
      u_prog.xfer(1'h1, 4'h0, {19'h0_0000, vs[i]}, q);
      dchk(prev);
      u_prog.xfer(1'h0, 4'h0, 32'h0000_0000, q);
      chk(q, {19'h0_0000, vs[i]});
      rst();
      dchk(vs[i]);
      prev = vs[i];
    end
    u_prog.xfer(1'h0, 4'h0, 32'h0000_0000, q);
    chk(q, 32'h0000_0000);
    u_prog.xfer(1'h0, 4'h4, 32'h0000_0000, q);
    chk(q, 32'h0000_0000);
    final_report;
  end
endmodule // owd_option_decoder_tb
